/* File: verilog/psg_top.sv */
// Purpose: sync (gating) pulse generator for a serial pattern source
// Assumes: cfg stable from apply until running or cfg_error
// Notes:   each mclk cycle with the stream on advances the pattern by one step of bits
`timescale 1ns/1ns
module psg_top (
	input  wire logic                  mclk,
	input  wire logic                  nrst,
	input  wire psg_pkg::psg_cfg_type  cfg,
	input  wire logic                  apply,
	input  wire logic                  stop,
	input  wire logic                  burst_gate,
	output psg_pkg::psg_status_type    status
);

	// ****************************************
	// control state
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_CALC  = 3'h1,
		ST_CHECK = 3'h2,
		ST_RUN   = 3'h3,
		ST_ERROR = 3'h4
	} psg_state_type;

	psg_state_type               state_reg, state_next;
	psg_pkg::psg_cfg_type        cfg_reg, cfg_next;
	logic [psg_pkg::POS_W-1:0]   period_reg, period_next;
	logic [psg_pkg::POS_W-1:0]   pos_reg, pos_next;
	logic [psg_pkg::POS_W-1:0]   hi_cnt_reg, hi_cnt_next;
	logic [psg_pkg::POS_W-1:0]   pat_pos_reg, pat_pos_next;
	psg_pkg::psg_status_type     status_reg, status_next;

	logic                        calc_start;
	logic                        calc_done;
	logic [psg_pkg::POS_W-1:0]   calc_period;
	logic [psg_pkg::POS_W-1:0]   step;
	logic [psg_pkg::POS_W-1:0]   gran;
	logic [psg_pkg::POS_W-1:0]   cap;
	logic [psg_pkg::POS_W-1:0]   mixed_len;
	logic [psg_pkg::POS_W-1:0]   pos_adv;
	logic [psg_pkg::POS_W-1:0]   pat_adv;
	logic                        is_mixed;
	logic                        burst_ok;
	logic                        len_ok;
	logic                        width_ok;
	logic                        delay_ok;
	logic                        cfg_ok;
	logic                        stream_on;
	logic                        wrap;

	// ****************************************
	// period derivation
	// ****************************************
	// the divider restarts on every accepted apply, even for mixed patterns
	assign calc_start = (state_reg == ST_IDLE || state_reg == ST_RUN
	                     || state_reg == ST_ERROR) && apply;

	psg_period_calc u_period_calc (
		.mclk        (mclk),
		.nrst        (nrst),
		.start       (calc_start),
		.combined    (cfg.combined),
		.pattern_len (cfg.pattern_len),
		.done        (calc_done),
		.period      (calc_period)
	);

	// ****************************************
	// range checks on the latched settings
	// ****************************************
	// ranges use the latched copy; the cfg port may move once running
	assign step      = cfg_reg.combined ? psg_pkg::STEP_COMBINED : psg_pkg::STEP_SINGLE;
	assign gran      = cfg_reg.combined ? psg_pkg::GRAN_COMBINED : psg_pkg::GRAN_SINGLE;
	assign is_mixed  = (cfg_reg.pattern == psg_pkg::PAT_MIXED)
	                   || (cfg_reg.pattern == psg_pkg::PAT_MIXED_PRBS);
	// three narrow fields; 40 bits hold the largest product
	assign mixed_len = {1'b0,
	                    40'(cfg_reg.row_len)
	                    * 40'(cfg_reg.row_count)
	                    * 40'(cfg_reg.block_count)};
	assign cap       = is_mixed ? psg_pkg::MAX_MIXED
	                   : (cfg_reg.combined ? psg_pkg::MAX_COMBINED
	                   : psg_pkg::MAX_SINGLE);

	// a value is legal when stepped, at least one granule, one granule short, and within the cap
	function automatic logic in_range(
		input logic [psg_pkg::POS_W-1:0] v,
		input logic [psg_pkg::POS_W-1:0] per,
		input logic [psg_pkg::POS_W-1:0] g,
		input logic [psg_pkg::POS_W-1:0] s,
		input logic [psg_pkg::POS_W-1:0] mx);
		logic ok;
		ok = ((v & (s - 41'h000_0000_0001)) == psg_pkg::POS_RESET);
		ok = ok && (v >= g) && (per >= (g + g)) && (v <= (per - g));
		ok = ok && (v <= mx);
		in_range = ok;
	endfunction

	assign len_ok   = is_mixed ? (mixed_len != psg_pkg::POS_RESET)
	                  : (cfg_reg.pattern_len != '0);
	assign width_ok = in_range(cfg_reg.pulse_width, period_reg, gran, step, cap);
	assign delay_ok = in_range(cfg_reg.delay, period_reg, gran, step, cap);
	assign burst_ok = (cfg_reg.seq == psg_pkg::SEQ_REPEAT)
	                  || (cfg_reg.pattern == psg_pkg::PAT_PRBS)
	                  || (cfg_reg.pattern == psg_pkg::PAT_DATA)
	                  || (cfg_reg.pattern == psg_pkg::zero_run_pattern_code)
	                  || (cfg_reg.pattern == psg_pkg::PAT_MIXED);
	assign cfg_ok   = len_ok && width_ok && delay_ok && burst_ok;

	// ****************************************
	// position counters
	// ****************************************
	// wrap is judged on the advanced count so no step of a period is lost
	assign pos_adv   = pos_reg + step;
	assign wrap      = (pos_adv >= period_reg);
	assign pat_adv   = pat_pos_reg + step;
	// burst streams only while the gate is open; repeat never pauses
	assign stream_on = (cfg_reg.seq == psg_pkg::SEQ_REPEAT) || burst_gate;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		state_next   = state_reg;
		cfg_next     = cfg_reg;
		period_next  = period_reg;
		pos_next     = pos_reg;
		hi_cnt_next  = hi_cnt_reg;
		pat_pos_next = pat_pos_reg;
		status_next  = status_reg;
		status_next.period_start = 1'b0;
		case (state_reg)
			ST_IDLE, ST_ERROR: begin
				if (apply) begin
					cfg_next   = cfg;
					state_next = ST_CALC;
					status_next.cfg_error = 1'b0;
				end
			end
			ST_CALC: begin
				// mixed period needs no extension, so no wait on the divider
				if (is_mixed) begin
					period_next = mixed_len;
					state_next  = ST_CHECK;
				end else if (calc_done) begin
					period_next = calc_period;
					state_next  = ST_CHECK;
				end
			end
			ST_CHECK: begin
				// cleared here so the first run cycle is the pattern start
				pos_next     = psg_pkg::POS_RESET;
				pat_pos_next = psg_pkg::POS_RESET;
				hi_cnt_next  = psg_pkg::POS_RESET;
				if (cfg_ok) begin
					state_next = ST_RUN;
					status_next.running      = 1'b1;
					status_next.period_start = 1'b1;
				end else begin
					state_next = ST_ERROR;
					status_next.cfg_error = 1'b1;
				end
			end
			ST_RUN: begin
				status_next.data_enable = stream_on;
				// a pulse cut by stop or apply is dropped, not finished
				if (stop || apply) begin
					state_next = apply ? ST_CALC : ST_IDLE;
					cfg_next   = apply ? cfg : cfg_reg;
					status_next.running     = 1'b0;
					status_next.sync_out    = 1'b0;
					status_next.data_enable = 1'b0;
				end else if (stream_on) begin
					pos_next     = wrap ? psg_pkg::POS_RESET : pos_adv;
					pat_pos_next = (pat_adv >= {9'h000, cfg_reg.pattern_len})
					               ? psg_pkg::POS_RESET : pat_adv;
					status_next.period_start = wrap;
					// pulse starts at the delay point, then lasts width bits
					if (pos_reg == cfg_reg.delay) begin
						status_next.sync_out = 1'b1;
						hi_cnt_next = step;
					end else if (status_reg.sync_out) begin
						if (hi_cnt_reg >= cfg_reg.pulse_width) begin
							status_next.sync_out = 1'b0;
						end else begin
							hi_cnt_next = hi_cnt_reg + step;
						end
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg   <= ST_IDLE;
			cfg_reg     <= '0;
			period_reg  <= psg_pkg::POS_RESET;
			pos_reg     <= psg_pkg::POS_RESET;
			hi_cnt_reg  <= psg_pkg::POS_RESET;
			pat_pos_reg <= psg_pkg::POS_RESET;
			status_reg  <= '0;
		end else begin
			state_reg   <= state_next;
			cfg_reg     <= cfg_next;
			period_reg  <= period_next;
			pos_reg     <= pos_next;
			hi_cnt_reg  <= hi_cnt_next;
			pat_pos_reg <= pat_pos_next;
			status_reg  <= status_next;
		end
	end

	assign status = status_reg;

endmodule

/* File: verilog/psg_pkg.sv */
// Purpose: shared constants and types of the pattern sync pulse generator
// Assumes: one mclk cycle carries one step of pattern bits (8, or 16 combined)
// Notes:   all lengths, widths and delays are counted in pattern bits
package psg_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int LEN_W = 32;
	localparam int EXT_W = 33;
	localparam int POS_W = 41;

	// ****************************************
	// quantization and range figures
	// ****************************************
	localparam logic [POS_W-1:0] STEP_SINGLE    = 41'h000_0000_0008;
	localparam logic [POS_W-1:0] STEP_COMBINED  = 41'h000_0000_0010;
	localparam logic [POS_W-1:0] GRAN_SINGLE    = 41'h000_0000_0080;
	localparam logic [POS_W-1:0] GRAN_COMBINED  = 41'h000_0000_0100;
	localparam logic [EXT_W-1:0] MIN_LEN_SINGLE = 33'h0_0000_0200;
	localparam logic [EXT_W-1:0] MIN_LEN_COMB   = 33'h0_0000_0400;
	localparam logic [POS_W-1:0] MAX_SINGLE     = 41'h007_FFFF_FF80;
	localparam logic [POS_W-1:0] MAX_COMBINED   = 41'h00F_FFFF_FF00;
	localparam logic [POS_W-1:0] MAX_MIXED      = 41'h000_8FFF_FF80;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [POS_W-1:0] POS_RESET = 41'h000_0000_0000;
	localparam logic [EXT_W-1:0] EXT_RESET = 33'h0_0000_0000;

	// ****************************************
	// enumerations
	// ****************************************
	typedef enum logic [2:0] {
		PAT_PRBS     = 3'h0,
		PAT_DATA     = 3'h1,
		zero_run_pattern_code = 3'h2,
		PAT_MIXED    = 3'h3,
		PAT_MIXED_PRBS = 3'h4,
		PAT_OTHER    = 3'h5
	} psg_pattern_type;

	typedef enum logic {
		SEQ_REPEAT = 1'h0,
		SEQ_BURST  = 1'h1
	} psg_seq_type;

	// ****************************************
	// configuration carrier, first_data_channel settings only
	// ****************************************
	typedef struct packed {
		psg_pattern_type   pattern;
		psg_seq_type       seq;
		logic              combined;
		logic [LEN_W-1:0]  pattern_len;
		logic [15:0]       row_len;
		logic [15:0]       row_count;
		logic [7:0]        block_count;
		logic [POS_W-1:0]  pulse_width;
		logic [POS_W-1:0]  delay;
	} psg_cfg_type;

	typedef struct packed {
		logic sync_out;
		logic data_enable;
		logic period_start;
		logic running;
		logic cfg_error;
	} psg_status_type;

endpackage

/* File: verilog/psg_period_calc.sv */
// Purpose: derives the effective repetition period from the pattern length
// Assumes: length nonzero; start is a one-cycle pulse
// Notes:   iterative, one add or shift per cycle; result stays until next start
`timescale 1ns/1ns
module psg_period_calc (
	input  wire logic                     mclk,
	input  wire logic                     nrst,
	input  wire logic                     start,
	input  wire logic                     combined,
	input  wire logic [psg_pkg::LEN_W-1:0] pattern_len,
	output logic                          done,
	output logic      [psg_pkg::POS_W-1:0] period
);

	// ****************************************
	// state
	// ****************************************
	typedef enum logic [1:0] {
		PC_IDLE   = 2'h0,
		PC_EXTEND = 2'h1,
		PC_ALIGN  = 2'h2
	} psg_pc_state_type;

	psg_pc_state_type              state_reg, state_next;
	logic [psg_pkg::POS_W-1:0]     acc_reg, acc_next;
	logic                          done_reg, done_next;
	logic [psg_pkg::EXT_W-1:0]     min_len;
	logic [psg_pkg::POS_W-1:0]     gran_mask;
	logic [psg_pkg::POS_W-1:0]     len_w;

	assign min_len   = combined ? psg_pkg::MIN_LEN_COMB : psg_pkg::MIN_LEN_SINGLE;
	assign gran_mask = (combined ? psg_pkg::GRAN_COMBINED : psg_pkg::GRAN_SINGLE)
	                   - 41'h000_0000_0001;
	assign len_w     = {9'h000, pattern_len};

	always_comb begin
		state_next = state_reg;
		acc_next   = acc_reg;
		done_next  = 1'b0;
		case (state_reg)
			PC_IDLE: begin
				if (start) begin
					acc_next   = len_w;
					state_next = PC_EXTEND;
				end
			end
			PC_EXTEND: begin
				// add whole lengths until the floor is reached
				if (len_w == psg_pkg::POS_RESET) begin
					// zero length never reaches the floor; hand back zero
					done_next  = 1'b1;
					state_next = PC_IDLE;
				end else if (acc_reg < {8'h00, min_len}) begin
					acc_next = acc_reg + len_w;
				end else begin
					state_next = PC_ALIGN;
				end
			end
			PC_ALIGN: begin
				// granule is a power of two, so the lcm is a doubling chain
				if ((acc_reg & gran_mask) != psg_pkg::POS_RESET) begin
					acc_next = {acc_reg[psg_pkg::POS_W-2:0], 1'b0};
				end else begin
					done_next  = 1'b1;
					state_next = PC_IDLE;
				end
			end
			default: begin
				state_next = PC_IDLE;
			end
		endcase
		// a new start aborts any run still going, so no stale result leaks
		if (start) begin
			acc_next   = len_w;
			state_next = PC_EXTEND;
			done_next  = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= PC_IDLE;
			acc_reg   <= psg_pkg::POS_RESET;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			acc_reg   <= acc_next;
			done_reg  <= done_next;
		end
	end

	assign done   = done_reg;
	assign period = acc_reg;

endmodule

/* File: dv/psg_properties.sv */
// Purpose: port checks of psg_top
// Assumes: cfg held steady while running
// Notes:   sync delay measured from period_start, sync width from the sync rise
`timescale 1ns/1ns
module psg_properties (
	input wire logic                    mclk,
	input wire logic                    nrst,
	input wire psg_pkg::psg_cfg_type    cfg,
	input wire logic                    apply,
	input wire logic                    stop,
	input wire logic                    burst_gate,
	input wire psg_pkg::psg_status_type status
);
	// ****
	// helper counters
	// ****
	logic [40:0] hi_reg;
	logic [40:0] hi_next;
	logic [40:0] since_reg;
	logic [40:0] since_next;
	logic [40:0] stp;
	logic [40:0] gran;
	always_comb begin
		stp = cfg.combined ? psg_pkg::STEP_COMBINED : psg_pkg::STEP_SINGLE;
		gran = cfg.combined ? psg_pkg::GRAN_COMBINED : psg_pkg::GRAN_SINGLE;
		hi_next = status.sync_out ? hi_reg + 41'h1 : 41'h0;
		since_next = status.period_start ? 41'h1 : since_reg + 41'h1;
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hi_reg <= 41'h0;
			since_reg <= 41'h0;
		end else begin
			hi_reg <= hi_next;
			since_reg <= since_next;
		end
	end
	// ****
	// properties
	// ****
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	chk_sync_in_run: assert property (status.sync_out |-> status.running)
		else $error("sync high outside run");
	chk_err_excl: assert property (!(status.running && status.cfg_error))
		else $error("running and error together");
	chk_ps_single: assert property (status.period_start |=> !status.period_start)
		else $error("period start wider than one cycle");
	chk_run_opens: assert property ($rose(status.running) |-> status.period_start)
		else $error("run began without period start");
	// frozen burst cycles would stretch the counts, so repeat mode only
	chk_width_len: assert property ($fell(status.sync_out) && status.running &&
		!$past(stop) && !$past(apply) && cfg.seq == psg_pkg::SEQ_REPEAT
		|-> hi_reg == cfg.pulse_width / stp) else $error("sync width wrong");
	chk_delay_pos: assert property ($rose(status.sync_out) &&
		cfg.seq == psg_pkg::SEQ_REPEAT |-> since_reg == cfg.delay / stp + 41'h1)
		else $error("sync delay wrong");
	chk_ok_steps: assert property ($rose(status.running) |->
		cfg.pulse_width % stp == 41'h0 && cfg.delay % stp == 41'h0)
		else $error("off-step setting accepted");
	chk_ok_floor: assert property ($rose(status.running) |->
		cfg.pulse_width >= gran && cfg.delay >= gran) else $error("short setting accepted");
	chk_burst_kind: assert property ($rose(status.running) &&
		cfg.seq == psg_pkg::SEQ_BURST |-> cfg.pattern inside {psg_pkg::PAT_PRBS,
		psg_pkg::PAT_DATA, psg_pkg::zero_run_pattern_code, psg_pkg::PAT_MIXED})
		else $error("burst accepted for wrong pattern");
endmodule
bind psg_top psg_properties chk_u (.mclk(mclk), .nrst(nrst), .cfg(cfg), .apply(apply),
	.stop(stop), .burst_gate(burst_gate), .status(status));

/* File: dv/psg_trig_sink.sv */
// Purpose: test gear that takes the gating pulse as a trigger
// Assumes: pulse sampled on mclk
// Notes:   counts rising edges only, like an edge trigger
`timescale 1ns/1ns
module psg_trig_sink (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        gate_in,
	output logic      [31:0] n_trig
);
	logic last_reg;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			last_reg <= 1'h0;
			n_trig <= 32'h0;
		end else begin
			last_reg <= gate_in;
			if (gate_in && !last_reg) begin
				n_trig <= n_trig + 32'h1;
			end
		end
	end
endmodule

/* File: dv/psg_top_tb.sv */
// Purpose: self-checking bench of psg_top
// Assumes: sync rises one cycle after the step count reaches delay
// Notes:   cfg held while running; stop before each new apply
`timescale 1ns/1ns
module psg_top_tb;
	logic                    mclk;
	logic                    nrst;
	logic                    apply;
	logic                    stop;
	logic                    burst_gate;
	psg_pkg::psg_cfg_type    cfg;
	psg_pkg::psg_status_type status;
	logic [31:0]             n_trig;
	int                      n_errors;
	int                      checks_done;
	always #25 mclk = ~mclk;
	psg_top dut_u (.mclk(mclk), .nrst(nrst), .cfg(cfg), .apply(apply), .stop(stop),
		.burst_gate(burst_gate), .status(status));
	psg_trig_sink sink_u (.mclk(mclk), .nrst(nrst), .gate_in(status.sync_out),
		.n_trig(n_trig));
	// ****
	// checking and model
	// ****
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cmp_bit(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %b", $time, what, got);
		end
	endtask
	task automatic cmp_num(input longint got, input longint exp, input string what);
		checks_done++;
		if (got != exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %0d want %0d", $time, what, got, exp);
		end
	endtask
	function automatic longint period_of(input psg_pkg::psg_cfg_type c);
		longint g, e, a, b, t;
		g = c.combined ? psg_pkg::GRAN_COMBINED : psg_pkg::GRAN_SINGLE;
		if (c.pattern inside {psg_pkg::PAT_MIXED, psg_pkg::PAT_MIXED_PRBS}) begin
			return longint'(c.row_len) * c.row_count * c.block_count;
		end
		e = c.pattern_len;
		while (e < 4 * g) e = e + c.pattern_len;
		a = e;
		b = g;
		while (b != 0) begin
			t = a % b;
			a = b;
			b = t;
		end
		return e / a * g;
	endfunction
	function automatic bit ok_cfg(input psg_pkg::psg_cfg_type c);
		longint g, s, p, cap;
		if (c.pattern_len == 0 &&
			!(c.pattern inside {psg_pkg::PAT_MIXED, psg_pkg::PAT_MIXED_PRBS})) return 0;
		if (c.seq == psg_pkg::SEQ_BURST && c.pattern > psg_pkg::PAT_MIXED) return 0;
		g = c.combined ? psg_pkg::GRAN_COMBINED : psg_pkg::GRAN_SINGLE;
		s = c.combined ? psg_pkg::STEP_COMBINED : psg_pkg::STEP_SINGLE;
		cap = c.combined ? psg_pkg::MAX_COMBINED : psg_pkg::MAX_SINGLE;
		if (c.pattern inside {psg_pkg::PAT_MIXED, psg_pkg::PAT_MIXED_PRBS}) cap = psg_pkg::MAX_MIXED;
		p = period_of(c);
		return c.pulse_width % s == 0 && c.delay % s == 0 && c.pulse_width >= g &&
			c.delay >= g && c.pulse_width <= p - g && c.delay <= p - g &&
			c.pulse_width <= cap && c.delay <= cap;
	endfunction
	function automatic psg_pkg::psg_cfg_type mk(input psg_pkg::psg_pattern_type pt,
		input psg_pkg::psg_seq_type sq, input logic cb, input logic [31:0] len,
		input logic [40:0] w, input logic [40:0] d);
		mk = '0;
		mk.pattern = pt;
		mk.seq = sq;
		mk.combined = cb;
		mk.pattern_len = len;
		mk.row_len = 16'h10;
		mk.row_count = 16'h4;
		mk.block_count = 8'h4;
		mk.pulse_width = w;
		mk.delay = d;
	endfunction
	// ****
	// one apply, then two periods measured
	// ****
	task automatic run_case(input psg_pkg::psg_cfg_type c);
		longint p, s, t, t0, t1, rise, fall, n0;
		bit ok;
		ok = ok_cfg(c);
		s = c.combined ? 16 : 8;
		@(negedge mclk) cfg = c;
		apply = 1'h1;
		@(negedge mclk) apply = 1'h0;
		for (t = 0; t < 300 && status.running !== 1'h1 && status.cfg_error !== 1'h1; t++)
			@(negedge mclk);
		cmp_bit(status.cfg_error, !ok, "refusal");
		if (ok) begin
			p = period_of(c) / s;
			n0 = n_trig;
			t0 = -1;
			t1 = -1;
			rise = -1;
			fall = -1;
			for (t = 0; t < 2 * p + 4; t++) begin
				if (status.period_start === 1'h1 && t0 >= 0 && t1 < 0) t1 = t;
				if (status.period_start === 1'h1 && t0 < 0) t0 = t;
				if (status.sync_out === 1'h1 && rise < 0 && t0 >= 0) rise = t;
				if (status.sync_out !== 1'h1 && rise >= 0 && fall < 0) fall = t;
				@(negedge mclk);
			end
			cmp_bit(status.data_enable, 1'h1, "stream");
			cmp_num(t1 - t0, p, "period");
			cmp_num(rise - t0, c.delay / s + 1, "delay");
			cmp_num(fall - rise, c.pulse_width / s, "width");
			cmp_num(n_trig - n0, 2, "triggers");
		end
		@(negedge mclk) stop = 1'h1;
		@(negedge mclk) stop = 1'h0;
		@(negedge mclk);
	endtask
	// ****
	// burst gate closed, then opened: delay 16 steps, period 64 steps
	// ****
	task automatic gate_case();
		longint t, n0;
		@(negedge mclk) cfg = mk(psg_pkg::PAT_PRBS, psg_pkg::SEQ_BURST, 0, 32'h200,
			41'h80, 41'h80);
		apply = 1'h1;
		@(negedge mclk) apply = 1'h0;
		for (t = 0; t < 300 && status.running !== 1'h1; t++)
			@(negedge mclk);
		burst_gate = 1'h0;
		n0 = n_trig;
		repeat (200) @(negedge mclk);
		cmp_bit(status.data_enable, 1'h0, "gate closed");
		cmp_num(n_trig - n0, 0, "frozen triggers");
		burst_gate = 1'h1;
		repeat (60) @(negedge mclk);
		cmp_bit(status.data_enable, 1'h1, "gate open");
		cmp_num(n_trig - n0, 1, "one trigger");
		@(negedge mclk) stop = 1'h1;
		@(negedge mclk) stop = 1'h0;
		@(negedge mclk);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		$display("[ERR] %0t timeout", $time);
		tally_and_finish();
	end
	initial begin
		psg_pkg::psg_cfg_type cm;
		mclk = 1'h0;
		nrst = 1'h0;
		apply = 1'h0;
		stop = 1'h0;
		burst_gate = 1'h1;
		cfg = '0;
		void'($urandom(32'hD883));
		repeat (4) @(negedge mclk);
		cmp_bit(|status, 1'h0, "reset");
		nrst = 1'h1;
		run_case(mk(psg_pkg::PAT_PRBS, psg_pkg::SEQ_REPEAT, 0, 32'h200, 41'h80, 41'h88));
		run_case(mk(psg_pkg::PAT_DATA, psg_pkg::SEQ_REPEAT, 0, 32'h12C, 41'h80, 41'h1240));
		run_case(mk(psg_pkg::zero_run_pattern_code, psg_pkg::SEQ_REPEAT, 1, 32'h12C,
			41'h100, 41'h11C0));
		run_case(mk(psg_pkg::PAT_MIXED, psg_pkg::SEQ_REPEAT, 0, 32'h1, 41'h80, 41'h80));
		run_case(mk(psg_pkg::PAT_MIXED, psg_pkg::SEQ_REPEAT, 1, 32'h1, 41'h100, 41'h100));
		run_case(mk(psg_pkg::PAT_PRBS, psg_pkg::SEQ_REPEAT, 0, 32'h200, 41'h84, 41'h80));
		run_case(mk(psg_pkg::PAT_PRBS, psg_pkg::SEQ_REPEAT, 0, 32'h200, 41'h78, 41'h80));
		run_case(mk(psg_pkg::PAT_PRBS, psg_pkg::SEQ_REPEAT, 0, 32'h200, 41'h80, 41'h188));
		run_case(mk(psg_pkg::PAT_PRBS, psg_pkg::SEQ_REPEAT, 0, 32'h0, 41'h80, 41'h80));
		for (int i = 0; i < 6; i++)
			run_case(mk(psg_pkg::psg_pattern_type'(i), psg_pkg::SEQ_BURST, 0, 32'h200,
				41'h80, 41'h80));
		for (int i = 0; i < 4; i++)
			run_case(mk(psg_pkg::PAT_PRBS, psg_pkg::SEQ_REPEAT, 1, 32'h200,
				41'(256 + 16 * ($urandom % 33)), 41'(256 + 16 * ($urandom % 33))));
		cm = mk(psg_pkg::PAT_MIXED, psg_pkg::SEQ_REPEAT, 0, 32'h1, 41'h000_8FFF_FF88, 41'h80);
		cm.row_len = 16'hFFFF;
		cm.row_count = 16'hFFFF;
		run_case(cm);
		run_case(mk(psg_pkg::PAT_PRBS, psg_pkg::SEQ_REPEAT, 0, 32'hFFFF_FFFF,
			41'h007_FFFF_FF88, 41'h80));
		run_case(mk(psg_pkg::PAT_DATA, psg_pkg::SEQ_REPEAT, 1, 32'hFFFF_FFFF,
			41'h00F_FFFF_FF10, 41'h100));
		gate_case();
		tally_and_finish();
	end
endmodule
